// *** inc/cla_pkg.sv ***
// Constants and types for the capacity learn and aging housekeeping block
package cla_pkg;
  // Register offsets on the register port
  localparam logic [7:0] CLA_OFS_SHUNT = 8'h00;
  localparam logic [7:0] CLA_OFS_VFULL = 8'h01;
  localparam logic [7:0] CLA_OFS_ITERM = 8'h02;
  localparam logic [7:0] CLA_OFS_VEMPTY = 8'h03;
  localparam logic [7:0] CLA_OFS_IEMPTY = 8'h04;
  localparam logic [7:0] CLA_OFS_RATED_HI = 8'h05;
  localparam logic [7:0] CLA_OFS_RATED_LO = 8'h06;
  localparam logic [7:0] CLA_OFS_AGE = 8'h07;
  localparam logic [7:0] CLA_OFS_STATUS = 8'h08;
  // Status bit positions
  localparam int CLA_BIT_FULL = 7;
  localparam int CLA_BIT_AEF = 6;
  localparam int CLA_BIT_LEARN = 4;
  // Values after reset
  localparam logic [7:0] CLA_RST_BYTE = 8'h00;
  localparam logic [15:0] CLA_RST_RATED = 16'h0000;
  localparam logic [7:0] CLA_RST_AGE = 8'h80;
  // Age scaler limits
  localparam logic [7:0] CLA_AGE_FULL = 8'h80;
  localparam logic [7:0] CLA_AGE_FLOOR = 8'h40;
  // Aging period is 2^5 = 32 rated charges
  localparam int CLA_AGE_SHIFT = 5;
  // Threshold scaling onto reading LSBs
  localparam int CLA_VOLT_SHIFT = 2;
  localparam int CLA_ITERM_SHIFT = 5;
  localparam int CLA_IEMPTY_SHIFT = 7;
  localparam logic signed [15:0] CLA_MIN_CHG = 16'sh0010;
  // Relative capacity clear points in percent
  localparam logic [7:0] CLA_AEF_CLR_PCT = 8'h05;
  localparam logic [7:0] CLA_FULL_CLR_PCT = 8'h5A;
  // Quotient bits of the learn divider
  localparam logic [2:0] CLA_DIV_STEPS = 3'h7;
  // Housekeeping sequencer states
  typedef enum logic [1:0] {
    CLA_ST_IDLE = 2'b00,
    CLA_ST_DIV = 2'b01,
    CLA_ST_LOAD = 2'b10
  } cla_state_t;
endpackage

// *** rtl/cla_full_detect.sv ***
// Full charge detector on voltage and mean current samples
`timescale 1ns/1ps
module cla_full_detect
  import cla_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic volt_tick,
  input wire logic [9:0] volt_reading,
  input wire logic avg_tick,
  input wire logic signed [15:0] mean_current_reading,
  input wire logic [7:0] full_voltage_threshold,
  input wire logic [7:0] termination_current_threshold,
  output logic full_pulse
);
  logic [1:0] qual_q, qual_d; // Qualifying averages so far
  logic volt_ok; // Voltage above full threshold
  logic avg_ok; // Average inside charge window
  logic signed [15:0] iterm; // Threshold on reading LSBs

  // Qualifier terms
  always_comb begin
    volt_ok = volt_reading[9:CLA_VOLT_SHIFT] > full_voltage_threshold;
    iterm = 16'(termination_current_threshold) <<< CLA_ITERM_SHIFT;
    avg_ok = (mean_current_reading > CLA_MIN_CHG) && (mean_current_reading < iterm);
  end

  // Count two averages with voltage high throughout
  always_comb begin
    qual_d = qual_q;
    full_pulse = 1'b0;
    if (volt_tick && !volt_ok) begin
      qual_d = 2'h0;
    end else if (avg_tick) begin
      if (!avg_ok) begin
        qual_d = 2'h0;
      end else if (qual_q == 2'h1) begin
        qual_d = 2'h0;
        full_pulse = 1'b1;
      end else begin
        qual_d = 2'h1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      qual_q <= 2'h0;
    end else begin
      qual_q <= qual_d;
    end
  end

  full_avg_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    full_pulse |-> avg_tick && avg_ok && qual_q == 2'h1)
    else $error("full without a qualifying average");
  full_volt_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (volt_tick && !volt_ok) |=> !full_pulse)
    else $error("full right after low voltage");
endmodule

// *** rtl/cla_empty_detect.sv ***
// Low-voltage and active-empty point detector; the active-empty flag itself is held in cla_top
`timescale 1ns/1ps
module cla_empty_detect
  import cla_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic volt_tick,
  input wire logic [9:0] volt_reading,
  input wire logic cur_tick,
  input wire logic signed [15:0] cur_reading,
  input wire logic [7:0] empty_voltage_threshold,
  input wire logic [7:0] empty_current_threshold,
  output logic volt_low,
  output logic empty_point
);
  logic [1:0] dis_q, dis_d; // Last two readings were heavy discharge
  logic signed [15:0] ilimit; // Threshold on reading LSBs

  // Heavy discharge history
  always_comb begin
    ilimit = 16'(empty_current_threshold) <<< CLA_IEMPTY_SHIFT;
    volt_low = volt_tick && (volt_reading[9:CLA_VOLT_SHIFT] < empty_voltage_threshold);
    empty_point = volt_low && (&dis_q);
    dis_d = dis_q;
    if (cur_tick) begin
      dis_d = {dis_q[0], (cur_reading < 16'sh0000) && (-cur_reading > ilimit)};
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dis_q <= 2'b00;
    end else begin
      dis_q <= dis_d;
    end
  end

  point_hist_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    empty_point |-> volt_low && dis_q == 2'b11)
    else $error("empty point without discharge history");
  point_light_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cur_tick && cur_reading >= 16'sh0000) |=> !empty_point)
    else $error("empty point after a charging reading");
endmodule

// *** rtl/cla_top.sv ***
// Capacity learn, aging estimation and coulomb count housekeeping
`timescale 1ns/1ps
module cla_top
  import cla_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic volt_tick,
  input wire logic [9:0] volt_reading,
  input wire logic cur_tick,
  input wire logic signed [15:0] cur_reading,
  input wire logic avg_tick,
  input wire logic signed [15:0] mean_current_reading,
  input wire logic count_dec,
  input wire logic [15:0] coulomb_count,
  input wire logic [15:0] full_model,
  input wire logic [15:0] empty_model,
  input wire logic [7:0] relative_active_capacity,
  input wire logic nv_load,
  input wire logic [7:0] nv_age_scaler,
  output logic count_load,
  output logic [15:0] count_load_value,
  output logic nv_save,
  output logic [7:0] age_scaler,
  output logic [7:0] shunt_conductance,
  output logic charge_full_flag,
  output logic active_empty_flag,
  output logic learn_cycle_flag
);
  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic [1:0] rst_sync_q; // Release synchroniser
  logic rst_n; // Synchronised reset

  // Two flops release the reset to the clock
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ------------------------------------------------------------
  // Detectors
  // ------------------------------------------------------------
  logic full_pulse; // Full charge detected
  logic volt_low; // Voltage under empty threshold
  logic empty_point; // Active-empty point detected
  logic [7:0] vfull_q, vfull_d; // Full voltage threshold
  logic [7:0] iterm_q, iterm_d; // Termination current threshold
  logic [7:0] vempty_q, vempty_d; // Empty voltage threshold
  logic [7:0] iempty_q, iempty_d; // Empty current threshold

  cla_full_detect u_full (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .volt_tick(volt_tick),
    .volt_reading(volt_reading),
    .avg_tick(avg_tick),
    .mean_current_reading(mean_current_reading),
    .full_voltage_threshold(vfull_q),
    .termination_current_threshold(iterm_q),
    .full_pulse(full_pulse)
  );

  cla_empty_detect u_empty (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .volt_tick(volt_tick),
    .volt_reading(volt_reading),
    .cur_tick(cur_tick),
    .cur_reading(cur_reading),
    .empty_voltage_threshold(vempty_q),
    .empty_current_threshold(iempty_q),
    .volt_low(volt_low),
    .empty_point(empty_point)
  );

  // ------------------------------------------------------------
  // Parameter registers
  // ------------------------------------------------------------
  logic [7:0] shunt_q, shunt_d; // Shunt conductance in mhos
  logic [15:0] rated_q, rated_d; // Rated charge for aging
  logic [7:0] rdata_d; // Read mux

  // Host writes to parameters
  always_comb begin
    shunt_d = shunt_q;
    vfull_d = vfull_q;
    iterm_d = iterm_q;
    vempty_d = vempty_q;
    iempty_d = iempty_q;
    rated_d = rated_q;
    if (reg_wr) begin
      if (reg_addr == CLA_OFS_SHUNT) begin
        shunt_d = reg_wdata;
      end else if (reg_addr == CLA_OFS_VFULL) begin
        vfull_d = reg_wdata;
      end else if (reg_addr == CLA_OFS_ITERM) begin
        iterm_d = reg_wdata;
      end else if (reg_addr == CLA_OFS_VEMPTY) begin
        vempty_d = reg_wdata;
      end else if (reg_addr == CLA_OFS_IEMPTY) begin
        iempty_d = reg_wdata;
      end else if (reg_addr == CLA_OFS_RATED_HI) begin
        rated_d = {reg_wdata, rated_q[7:0]};
      end else if (reg_addr == CLA_OFS_RATED_LO) begin
        rated_d = {rated_q[15:8], reg_wdata};
      end
    end
  end

  // Parameter flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shunt_q <= CLA_RST_BYTE;
      vfull_q <= CLA_RST_BYTE;
      iterm_q <= CLA_RST_BYTE;
      vempty_q <= CLA_RST_BYTE;
      iempty_q <= CLA_RST_BYTE;
      rated_q <= CLA_RST_RATED;
    end else begin
      shunt_q <= shunt_d;
      vfull_q <= vfull_d;
      iterm_q <= iterm_d;
      vempty_q <= vempty_d;
      iempty_q <= iempty_d;
      rated_q <= rated_d;
    end
  end

  // ------------------------------------------------------------
  // Flags, aging and housekeeping
  // ------------------------------------------------------------
  cla_state_t st_q, st_d; // Housekeeping sequencer
  logic [7:0] age_q, age_d; // Age scaler
  logic [20:0] wear_q, wear_d; // Discharge count toward one aging step
  logic [20:0] wear_limit; // 32 times rated charge
  logic full_q, full_d; // Charge full flag
  logic aef_q, aef_d; // Active-empty flag
  logic learn_q, learn_d; // Learn cycle flag
  logic learned_q, learned_d; // Full ended a learn cycle
  logic [16:0] rem_q, rem_d; // Divider remainder
  logic [6:0] quo_q, quo_d; // Divider quotient
  logic [2:0] step_q, step_d; // Divider steps left
  logic load_q, load_d; // Count load strobe
  logic [15:0] load_val_q, load_val_d; // Count load value
  logic save_q, save_d; // Save request to memory
  logic [23:0] scaled_full; // Full model times age scaler
  logic [16:0] rem_shift; // Remainder shifted for next bit

  // Flags, aging, learn division and count corrections
  always_comb begin
    st_d = st_q;
    age_d = age_q;
    wear_d = wear_q;
    full_d = full_q;
    aef_d = aef_q;
    learn_d = learn_q;
    learned_d = learned_q;
    rem_d = rem_q;
    quo_d = quo_q;
    step_d = step_q;
    load_d = 1'b0;
    load_val_d = load_val_q;
    save_d = 1'b0;
    wear_limit = {rated_q, 5'h00};
    scaled_full = full_model * age_q;
    rem_shift = {rem_q[15:0], 1'b0};
    // Full flag clears on low relative capacity, detection wins
    if (relative_active_capacity < CLA_FULL_CLR_PCT) begin
      full_d = 1'b0;
    end
    // Empty flag clears above 5 percent, low voltage wins
    if (relative_active_capacity > CLA_AEF_CLR_PCT) begin
      aef_d = 1'b0;
    end
    if (volt_low) begin
      aef_d = 1'b1;
    end
    // Learn flag drops on discharge or an empty count
    if ((cur_tick && cur_reading < 16'sh0000) || coulomb_count == 16'h0000) begin
      learn_d = 1'b0;
    end
    if (empty_point) begin
      learn_d = 1'b1;
    end
    case (st_q)
      CLA_ST_IDLE: begin
        if (full_pulse) begin
          full_d = 1'b1;
          learn_d = 1'b0;
          learned_d = learn_q;
          if (learn_q && coulomb_count >= full_model) begin
            age_d = CLA_AGE_FULL;
            save_d = age_q != CLA_AGE_FULL;
            st_d = CLA_ST_LOAD;
          end else if (learn_q) begin
            rem_d = {1'b0, coulomb_count};
            quo_d = 7'h00;
            step_d = CLA_DIV_STEPS;
            st_d = CLA_ST_DIV;
          end else begin
            st_d = CLA_ST_LOAD;
          end
        end else if (empty_point || (volt_tick && learn_q && volt_low)) begin
          load_d = 1'b1;
          load_val_d = empty_model;
        end else if (volt_tick && aef_q && !learn_q && coulomb_count > empty_model) begin
          load_d = 1'b1;
          load_val_d = empty_model;
        end else if (count_dec && rated_q != 16'h0000) begin
          if (wear_q + 21'h000001 >= wear_limit) begin
            wear_d = 21'h000000;
            if (age_q > CLA_AGE_FLOOR) begin
              age_d = age_q - 8'h01;
              save_d = 1'b1;
            end
          end else begin
            wear_d = wear_q + 21'h000001;
          end
        end
      end
      CLA_ST_DIV: begin
        // One quotient bit per cycle, scaler untouched until done
        if (rem_shift >= {1'b0, full_model}) begin
          rem_d = rem_shift - {1'b0, full_model};
          quo_d = {quo_q[5:0], 1'b1};
        end else begin
          rem_d = rem_shift;
          quo_d = {quo_q[5:0], 1'b0};
        end
        step_d = step_q - 3'h1;
        if (step_q == 3'h1) begin
          // Whole new value in one cycle, floored at 50 percent
          age_d = ({1'b0, quo_d} < CLA_AGE_FLOOR) ? CLA_AGE_FLOOR : {1'b0, quo_d};
          save_d = 1'b1;
          st_d = CLA_ST_LOAD;
        end
      end
      CLA_ST_LOAD: begin
        // Scaled full model with the settled scaler
        load_d = 1'b1;
        load_val_d = scaled_full[22:7];
        learned_d = 1'b0;
        st_d = CLA_ST_IDLE;
      end
      default: begin
        st_d = CLA_ST_IDLE;
      end
    endcase
    // Host write or memory recall of the scaler overrides
    if (nv_load) begin
      age_d = nv_age_scaler;
    end else if (reg_wr && reg_addr == CLA_OFS_AGE) begin
      age_d = reg_wdata;
      save_d = 1'b1;
    end
  end

  // Housekeeping flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= CLA_ST_IDLE;
      age_q <= CLA_RST_AGE;
      wear_q <= 21'h000000;
      full_q <= 1'b0;
      aef_q <= 1'b0;
      learn_q <= 1'b0;
      learned_q <= 1'b0;
      rem_q <= 17'h00000;
      quo_q <= 7'h00;
      step_q <= 3'h0;
      load_q <= 1'b0;
      load_val_q <= 16'h0000;
      save_q <= 1'b0;
    end else begin
      st_q <= st_d;
      age_q <= age_d;
      wear_q <= wear_d;
      full_q <= full_d;
      aef_q <= aef_d;
      learn_q <= learn_d;
      learned_q <= learned_d;
      rem_q <= rem_d;
      quo_q <= quo_d;
      step_q <= step_d;
      load_q <= load_d;
      load_val_q <= load_val_d;
      save_q <= save_d;
    end
  end

  // ------------------------------------------------------------
  // Read port and outputs
  // ------------------------------------------------------------
  // Read mux, unmapped offsets read zero
  always_comb begin
    rdata_d = 8'h00;
    if (reg_addr == CLA_OFS_SHUNT) begin
      rdata_d = shunt_q;
    end else if (reg_addr == CLA_OFS_VFULL) begin
      rdata_d = vfull_q;
    end else if (reg_addr == CLA_OFS_ITERM) begin
      rdata_d = iterm_q;
    end else if (reg_addr == CLA_OFS_VEMPTY) begin
      rdata_d = vempty_q;
    end else if (reg_addr == CLA_OFS_IEMPTY) begin
      rdata_d = iempty_q;
    end else if (reg_addr == CLA_OFS_RATED_HI) begin
      rdata_d = rated_q[15:8];
    end else if (reg_addr == CLA_OFS_RATED_LO) begin
      rdata_d = rated_q[7:0];
    end else if (reg_addr == CLA_OFS_AGE) begin
      rdata_d = age_q;
    end else if (reg_addr == CLA_OFS_STATUS) begin
      rdata_d[CLA_BIT_FULL] = full_q;
      rdata_d[CLA_BIT_AEF] = aef_q;
      rdata_d[CLA_BIT_LEARN] = learn_q;
    end
  end

  // Registered read data
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  assign count_load = load_q;
  assign count_load_value = load_val_q;
  assign nv_save = save_q;
  assign age_scaler = age_q;
  assign shunt_conductance = shunt_q;
  assign charge_full_flag = full_q;
  assign active_empty_flag = aef_q;
  assign learn_cycle_flag = learn_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  age_floor_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(age_q) >= CLA_AGE_FLOOR && !$past(nv_load) && !$past(reg_wr))
      |-> age_q >= CLA_AGE_FLOOR)
    else $error("age scaler went below floor");
  full_flags_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_q == CLA_ST_IDLE && full_pulse) |=> full_q && !learn_q)
    else $error("full did not set full and clear learn");
  learn_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (empty_point && st_q == CLA_ST_IDLE) |=> learn_q && load_q && load_val_q == $past(empty_model))
    else $error("empty point did not start learn");
  load_order_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_q == CLA_ST_DIV) |-> !load_q [*2])
    else $error("count loaded before scaler settled");
  full_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_q == CLA_ST_LOAD) |=> load_q && load_val_q == $past(scaled_full[22:7]))
    else $error("full load value wrong");
  empty_lower_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (load_q && !learn_q && $past(st_q) == CLA_ST_IDLE) |-> load_val_q < $past(coulomb_count)
      || $past(empty_point) || $past(learn_q))
    else $error("empty correction raised the count");
  aef_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    volt_low |=> aef_q)
    else $error("empty flag missed low voltage");
  wear_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_q == CLA_ST_IDLE && !full_pulse && !empty_point && !volt_tick && count_dec
      && rated_q != 16'h0000 && !nv_load && !reg_wr && age_q > CLA_AGE_FLOOR
      && wear_q + 21'h000001 >= wear_limit) |=> age_q == $past(age_q) - 8'h01 && save_q)
    else $error("aging step missed");
endmodule

// *** test/cla_host_model.sv ***
// Host model driving the parameter register port
`timescale 1ns/1ps
module cla_host_model
  import cla_pkg::*;
(
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic clk_sys
);
  // ----
  // Idle port levels
  // ----
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // One strobe, address and data held through the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // Address held, data taken after the answering edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    @(posedge clk_sys);
    #1 d = reg_rdata;
  endtask
  // Start of life preset near 95 percent
  task automatic preset();
    wr(CLA_OFS_AGE, 8'h7A);
  endtask
  // A scaler at its floor asks for a learn cycle
  task automatic floor_prompt(output logic p);
    logic [7:0] d;
    rd(CLA_OFS_AGE, d);
    p = (d === CLA_AGE_FLOOR);
  endtask
endmodule

// *** test/capacity_learn_aging_housekeeping_test.sv ***
// Self-checking bench for the capacity learn and aging block
`timescale 1ns/1ps
module capacity_learn_aging_housekeeping_test;
  import cla_pkg::*;
  // ----
  // Signals
  // ----
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic reg_wr;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [4:0] tk = 5'h00; // Pulses: nv_load, count_dec, avg, cur, volt
  logic [9:0] volt_reading = 10'h3FC;
  logic signed [15:0] cur_reading = 16'sh0000;
  logic signed [15:0] mean_current_reading = 16'sh0000;
  logic [15:0] coulomb_count = 16'h0300;
  logic [15:0] full_model = 16'h0800;
  logic [15:0] empty_model = 16'h0200;
  logic [7:0] relative_active_capacity = 8'h00;
  logic [7:0] nv_age_scaler = 8'h55;
  logic count_load, nv_save, charge_full_flag, active_empty_flag, learn_cycle_flag;
  logic [15:0] count_load_value, load_val;
  logic [7:0] age_scaler, shunt_conductance, load_age;
  logic [31:0] seed = 32'h6A27FF77;
  int failures = 0, comparisons = 0, loads = 0, saves = 0, cyc = 0;
  always #4 clk_sys = ~clk_sys;
  cla_host_model i_host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  cla_top i_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .volt_tick(tk[0]),
    .volt_reading(volt_reading), .cur_tick(tk[1]), .cur_reading(cur_reading),
    .avg_tick(tk[2]), .mean_current_reading(mean_current_reading), .count_dec(tk[3]),
    .coulomb_count(coulomb_count), .full_model(full_model), .empty_model(empty_model),
    .relative_active_capacity(relative_active_capacity), .nv_load(tk[4]),
    .nv_age_scaler(nv_age_scaler), .count_load(count_load),
    .count_load_value(count_load_value), .nv_save(nv_save), .age_scaler(age_scaler),
    .shunt_conductance(shunt_conductance), .charge_full_flag(charge_full_flag),
    .active_empty_flag(active_empty_flag), .learn_cycle_flag(learn_cycle_flag));
  // ----
  // Pulse monitor and hang guard
  // ----
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (count_load === 1'b1) begin
      loads <= loads + 1;
      load_val <= count_load_value;
      load_age <= age_scaler;
    end
    if (nv_save === 1'b1) saves <= saves + 1;
    if (cyc == 6000) begin
      failures = failures + 1;
      test_done();
    end
  end
  // Scaler learned from the count at full
  function automatic logic [7:0] learned(input logic [15:0] c, input logic [15:0] f);
    logic [31:0] q;
    q = ({16'h0000, c} << 7) / f;
    if (q > 32'h80) q = 32'h80;
    if (q < 32'h40) q = 32'h40;
    return q[7:0];
  endfunction
  // Full model value scaled by age
  function automatic logic [15:0] scaled(input logic [15:0] f, input logic [7:0] a);
    logic [23:0] p;
    p = f * a;
    return p[22:7];
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  // One-cycle tick group, then settle well past the slowest answer
  task automatic meas(input logic [4:0] m);
    loads = 0;
    @(posedge clk_sys);
    tk <= m;
    @(posedge clk_sys);
    tk <= 5'h00;
    repeat (14) @(posedge clk_sys);
    #1;
  endtask
  task automatic test_done();
    $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    logic [7:0] d;
    logic [7:0] v [8];
    logic p;
    logic signed [15:0] avgs [5];
    avgs = '{16'sd40, 16'sd16, -16'sd40, 16'sd64, 16'sd40};
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int a = 0; a < 10; a++) begin
      i_host.rd(a[7:0], d);
      chk("reset value", (a == 7) ? 16'h0080 : 16'h0000, {8'h00, d});
    end
    for (int a = 0; a < 8; a++) begin
      seed = xs(seed);
      v[a] = (a == 7) ? {2'b01, seed[5:0]} : seed[7:0];
      i_host.wr(a[7:0], v[a]);
    end
    i_host.wr(CLA_OFS_STATUS, 8'hFF);
    for (int a = 0; a < 9; a++) begin
      i_host.rd(a[7:0], d);
      chk("register", (a == 8) ? 16'h0000 : {8'h00, v[a]}, {8'h00, d});
    end
    chk("shunt", {8'h00, v[0]}, {8'h00, shunt_conductance});
    $display("Finished: registers");
    saves = 0;
    i_host.preset();
    repeat (2) @(posedge clk_sys);
    #1;
    chk("save pulses", 16'h0001, saves[15:0]);
    meas(5'h10);
    chk("recalled scaler", 16'h0055, {8'h00, age_scaler});
    i_host.wr(CLA_OFS_RATED_HI, 8'h00);
    i_host.wr(CLA_OFS_RATED_LO, 8'h01);
    i_host.wr(CLA_OFS_AGE, 8'h41);
    for (int n = 1; n <= 64; n++) begin
      meas(5'h08);
      if (n == 31 || n == 32 || n == 64)
        chk("aged scaler", (n == 31) ? 16'h41 : 16'h40, {8'h00, age_scaler});
    end
    i_host.floor_prompt(p);
    chk("floor prompt", 16'h0001, {15'h0, p});
    $display("Finished: aging");
    i_host.wr(CLA_OFS_VEMPTY, 8'h80);
    i_host.wr(CLA_OFS_IEMPTY, 8'h01);
    @(posedge clk_sys);
    cur_reading <= -16'sd200;
    volt_reading <= 10'h100;
    meas(5'h02);
    meas(5'h02);
    meas(5'h01);
    chk("empty loads", 16'h0001, loads[15:0]);
    chk("empty value", empty_model, load_val);
    chk("empty flags", 16'h0003, {14'h0, active_empty_flag, learn_cycle_flag});
    i_host.wr(CLA_OFS_VFULL, 8'h80);
    i_host.wr(CLA_OFS_ITERM, 8'h02);
    @(posedge clk_sys);
    relative_active_capacity <= 8'd100;
    coulomb_count <= 16'h0600;
    for (int t = 0; t < 5; t++) begin
      @(posedge clk_sys);
      mean_current_reading <= avgs[t];
      volt_reading <= (t == 0) ? 10'h200 : 10'h3FC;
      meas(5'h04);
      meas(5'h01);
      @(posedge clk_sys);
      volt_reading <= 10'h3FC;
      meas(5'h04);
      chk("full flag", {15'h0, t == 4}, {15'h0, charge_full_flag});
    end
    chk("full loads", 16'h0001, loads[15:0]);
    chk("learned scaler", {8'h00, learned(16'h0600, 16'h0800)}, {8'h00, load_age});
    chk("full value", scaled(16'h0800, learned(16'h0600, 16'h0800)), load_val);
    chk("after full", 16'h0000, {14'h0, active_empty_flag, learn_cycle_flag});
    i_host.rd(CLA_OFS_STATUS, d);
    chk("status", 16'h0080, {8'h00, d});
    $display("Finished: learn");
    @(posedge clk_sys);
    relative_active_capacity <= 8'd0;
    cur_reading <= -16'sd1;
    volt_reading <= 10'h100;
    coulomb_count <= 16'h0300;
    meas(5'h02);
    meas(5'h01);
    // First low reading only raises the empty flag, the next one lowers the count
    meas(5'h01);
    chk("lower loads", 16'h0001, loads[15:0]);
    chk("lowered count", empty_model, load_val);
    chk("lower flags", 16'h0002, {14'h0, active_empty_flag, learn_cycle_flag});
    @(posedge clk_sys);
    coulomb_count <= 16'h0100;
    meas(5'h01);
    chk("count kept", 16'h0000, loads[15:0]);
    // Learn cycle with the count past full saturates the scaler
    @(posedge clk_sys);
    cur_reading <= -16'sd200;
    meas(5'h02);
    meas(5'h02);
    meas(5'h01);
    @(posedge clk_sys);
    relative_active_capacity <= 8'd100;
    volt_reading <= 10'h3FC;
    coulomb_count <= 16'h0900;
    meas(5'h04);
    meas(5'h04);
    chk("saturated loads", 16'h0001, loads[15:0]);
    chk("saturated scaler", 16'h0080, {8'h00, age_scaler});
    chk("saturated value", scaled(16'h0800, 8'h80), load_val);
    // Full without a learn cycle keeps the scaler and loads at once
    @(posedge clk_sys);
    full_model <= 16'h0400;
    meas(5'h04);
    meas(5'h04);
    chk("plain full loads", 16'h0001, loads[15:0]);
    chk("plain full value", scaled(16'h0400, 8'h80), load_val);
    $display("Finished: housekeeping");
    test_done();
  end
endmodule
